/* tac_pkg.sv */
// constants for the trace address compressor
// assumes a 250 MHz core clock and a separate trace port clock of at most 50 MHz
package tac_pkg;
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned DISP_W = 8;
    localparam logic [31:0] RESET_VECTOR = 32'hA0000000;
    // record length codes carried with each record
    localparam logic [1:0] LEN_4 = 2'h0;
    localparam logic [1:0] LEN_8 = 2'h1;
    localparam logic [1:0] LEN_16 = 2'h2;
    localparam logic [1:0] LEN_32 = 2'h3;
    // nibble counts sent on the port per length code
    localparam logic [3:0] NIB_4 = 4'h1;
    localparam logic [3:0] NIB_8 = 4'h2;
    localparam logic [3:0] NIB_16 = 4'h4;
    localparam logic [3:0] NIB_32 = 4'h8;
    // record kinds
    localparam logic [1:0] KIND_BRANCH = 2'h0;
    localparam logic [1:0] KIND_WINDOW = 2'h1;
    localparam logic [1:0] KIND_EXCEPT = 2'h2;
    localparam logic [31:0] NEXT_INSN_STEP = 32'h00000002;
    localparam int unsigned REC_W = 2 + 2 + 32;
    // trace port clock bound
    localparam int unsigned TRACE_CLK_MAX_MHZ = 50;
endpackage

/* tac_buf2.sv */
// two-entry valid/ready buffer
// assumes both sides on the same clock
`timescale 1ns/10ps
`default_nettype none
module tac_buf2 #(
    parameter int unsigned WIDTH = 36
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    logic [WIDTH-1:0] mem [2];
    logic [WIDTH-1:0] next_mem [2];
    logic wptr, rptr, next_wptr, next_rptr;
    logic [1:0] count, next_count;
    logic push, pop;

    always_comb begin
        push = in_valid_i && (count != 2'h2);
        pop = out_ready_i && (count != 2'h0);
        next_mem = mem;
        next_wptr = wptr;
        next_rptr = rptr;
        next_count = count;
        if (push) begin
            next_mem[wptr] = in_data_i;
            next_wptr = ~wptr;
        end
        if (pop) begin
            next_rptr = ~rptr;
        end
        next_count = count + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            mem[0] <= '0;
            mem[1] <= '0;
            wptr <= 1'b0;
            rptr <= 1'b0;
            count <= 2'h0;
        end else begin
            mem <= next_mem;
            wptr <= next_wptr;
            rptr <= next_rptr;
            count <= next_count;
        end
    end

    assign in_ready_o = (count != 2'h2);
    assign out_valid_o = (count != 2'h0);
    assign out_data_o = mem[rptr];
endmodule
`default_nettype wire

/* tac_compressor.sv */
// trace address compressor: compresses branch and window addresses, sends nibbles on the trace port
// assumes cpu-side events on core_clk_i and a trace port clock of at most 50 MHz from the emulator
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - branch source addresses are sent as difference from the previous output
// - window trace addresses are sent as difference from the previous output
// - upper 16 bits equal: send lower 16 bits only
// - upper 24 bits equal: send lower 8 bits only
// - upper 28 bits equal: send lower 4 bits only
// - no record for conditional branches with zero displacement
// - no record for the reset branch to the reset vector
// - completion exceptions record the address after the faulting instruction
// - realtime mode keeps the cpu running and may drop records
// - non-realtime mode stalls the cpu until output completes
module tac_compressor (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic trace_port_clock_i,
    input wire logic trace_resetn_i,
    input wire logic realtime_mode_i,
    input wire logic branch_en_i,
    input wire logic window_en_i,
    input wire logic branch_valid_i,
    input wire logic [31:0] branch_src_i,
    input wire logic branch_cond_i,
    input wire logic [7:0] branch_disp_i,
    input wire logic branch_reset_i,
    input wire logic branch_except_i,
    input wire logic except_completion_i,
    input wire logic window_valid_i,
    input wire logic [31:0] window_addr_i,
    output logic cpu_stall_o,
    output logic drop_o,
    output logic [3:0] trace_output_port_o,
    output logic trace_sync_o
);
    typedef enum logic [2:0] {
        TAC_IDLE = 3'b001,
        TAC_HEAD = 3'b010,
        TAC_DATA = 3'b100
    } tac_state_type;

    // capture side (core clock)
    logic [31:0] last_addr, next_last_addr;
    logic in_valid, in_ready;
    logic [35:0] in_data;
    logic out_valid, out_ready;
    logic [35:0] out_data;
    logic stall, next_stall;
    logic drop, next_drop;
    logic want;
    logic [1:0] kind;
    logic [31:0] addr;
    logic [1:0] len;
    // handshake toward link domain
    logic req_tgl, next_req_tgl;
    logic [35:0] hold, next_hold;
    logic busy, next_busy;
    logic ack_s1, ack_s2, ack_s3;
    logic ack_tgl, next_ack_tgl;

    always_comb begin
        want = 1'b0;
        kind = tac_pkg::KIND_BRANCH;
        addr = branch_src_i;
        if (branch_valid_i && branch_en_i
            && !(branch_cond_i && branch_disp_i == 8'h00)
            && !(branch_reset_i && branch_src_i == tac_pkg::RESET_VECTOR)) begin
            want = 1'b1;
            if (branch_except_i && except_completion_i) begin
                kind = tac_pkg::KIND_EXCEPT;
                addr = branch_src_i + tac_pkg::NEXT_INSN_STEP;
            end
        end else if (window_valid_i && window_en_i) begin
            want = 1'b1;
            kind = tac_pkg::KIND_WINDOW;
            addr = window_addr_i;
        end
        if (addr[31:4] == last_addr[31:4]) begin
            len = tac_pkg::LEN_4;
        end else if (addr[31:8] == last_addr[31:8]) begin
            len = tac_pkg::LEN_8;
        end else if (addr[31:16] == last_addr[31:16]) begin
            len = tac_pkg::LEN_16;
        end else begin
            len = tac_pkg::LEN_32;
        end
        in_valid = want;
        in_data = {kind, len, addr};
        next_last_addr = last_addr;
        if (want && in_ready) begin
            next_last_addr = addr;
        end
        next_drop = want && !in_ready && realtime_mode_i;
        next_stall = !realtime_mode_i && (!in_ready || (want && busy));
        next_req_tgl = req_tgl;
        next_hold = hold;
        next_busy = busy;
        out_ready = 1'b0;
        if (busy) begin
            if (ack_s3 != ack_s2) begin
                next_busy = 1'b0;
            end
        end else if (out_valid) begin
            out_ready = 1'b1;
            next_hold = out_data;
            next_req_tgl = ~req_tgl;
            next_busy = 1'b1;
        end
    end

    tac_buf2 #(
        .WIDTH(tac_pkg::REC_W)
    ) u_buf (
        .clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .in_valid_i(in_valid),
        .in_ready_o(in_ready),
        .in_data_i(in_data),
        .out_valid_o(out_valid),
        .out_ready_i(out_ready),
        .out_data_o(out_data)
    );

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            last_addr <= 32'h00000000;
            stall <= 1'b0;
            drop <= 1'b0;
            req_tgl <= 1'b0;
            hold <= 36'h000000000;
            busy <= 1'b0;
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
            ack_s3 <= 1'b0;
        end else begin
            last_addr <= next_last_addr;
            stall <= next_stall;
            drop <= next_drop;
            req_tgl <= next_req_tgl;
            hold <= next_hold;
            busy <= next_busy;
            ack_s1 <= ack_tgl;
            ack_s2 <= ack_s1;
            ack_s3 <= ack_s2;
        end
    end

    assign cpu_stall_o = stall;
    assign drop_o = drop;

    // link side (trace port clock, at most 50 MHz)
    tac_state_type state, next_state;
    logic req_s1, req_s2, req_s3;
    logic [35:0] shreg, next_shreg;
    logic [3:0] nib_left, next_nib_left;
    logic [3:0] port, next_port;
    logic sync, next_sync;

    always_comb begin
        next_state = state;
        next_ack_tgl = ack_tgl;
        next_shreg = shreg;
        next_nib_left = nib_left;
        next_port = 4'h0;
        next_sync = 1'b0;
        case (state)
            TAC_IDLE: begin
                if (req_s3 != req_s2) begin
                    next_shreg = hold;
                    next_state = TAC_HEAD;
                end
            end
            TAC_HEAD: begin
                next_sync = 1'b1;
                next_port = shreg[35:32];
                case (shreg[33:32])
                    tac_pkg::LEN_4: next_nib_left = tac_pkg::NIB_4;
                    tac_pkg::LEN_8: next_nib_left = tac_pkg::NIB_8;
                    tac_pkg::LEN_16: next_nib_left = tac_pkg::NIB_16;
                    default: next_nib_left = tac_pkg::NIB_32;
                endcase
                next_state = TAC_DATA;
            end
            TAC_DATA: begin
                next_port = shreg[3:0];
                next_shreg = {shreg[35:32], 4'h0, shreg[31:4]};
                next_nib_left = nib_left - 4'h1;
                if (nib_left == 4'h1) begin
                    next_ack_tgl = ~ack_tgl;
                    next_state = TAC_IDLE;
                end
            end
            default: begin
                next_state = TAC_IDLE;
            end
        endcase
    end

    always_ff @(posedge trace_port_clock_i) begin
        if (!trace_resetn_i) begin
            state <= TAC_IDLE;
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_s3 <= 1'b0;
            ack_tgl <= 1'b0;
            shreg <= 36'h000000000;
            nib_left <= 4'h0;
            port <= 4'h0;
            sync <= 1'b0;
        end else begin
            state <= next_state;
            req_s1 <= req_tgl;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
            ack_tgl <= next_ack_tgl;
            shreg <= next_shreg;
            nib_left <= next_nib_left;
            port <= next_port;
            sync <= next_sync;
        end
    end

    assign trace_output_port_o = port;
    assign trace_sync_o = sync;

    zero_disp_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (branch_valid_i && branch_en_i && branch_cond_i && branch_disp_i == 8'h00 && !window_valid_i)
        |-> !in_valid) else $error("zero displacement branch traced");
    reset_branch_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (branch_valid_i && branch_reset_i && branch_src_i == tac_pkg::RESET_VECTOR && !window_valid_i)
        |-> !in_valid) else $error("reset vector branch traced");
    len4_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (in_valid && addr[31:4] == last_addr[31:4]) |-> len == tac_pkg::LEN_4) else $error("bad 4-bit length");
    len8_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (in_valid && addr[31:8] == last_addr[31:8] && addr[7:4] != last_addr[7:4])
        |-> len == tac_pkg::LEN_8) else $error("bad 8-bit length");
    len16_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (in_valid && addr[31:16] == last_addr[31:16] && addr[15:8] != last_addr[15:8])
        |-> len == tac_pkg::LEN_16) else $error("bad 16-bit length");
    len32_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (in_valid && addr[31:16] != last_addr[31:16]) |-> len == tac_pkg::LEN_32) else $error("bad 32-bit length");
    last_track_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (in_valid && in_ready) |=> last_addr == $past(addr)) else $error("reference address not updated");
    except_next_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (branch_valid_i && branch_en_i && branch_except_i && except_completion_i
        && !branch_cond_i && !branch_reset_i)
        |-> in_valid && in_data[31:0] == branch_src_i + tac_pkg::NEXT_INSN_STEP)
        else $error("exception address not advanced");
    stall_nrt_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (!realtime_mode_i && !in_ready) |=> cpu_stall_o) else $error("no stall in non-realtime mode");
    no_stall_rt_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        $past(realtime_mode_i) |-> !cpu_stall_o) else $error("stall in realtime mode");
    stall_busy_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (!realtime_mode_i && in_valid && busy) |=> cpu_stall_o)
        else $error("no stall on busy link");
    stall_clear_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (!realtime_mode_i && in_ready && !(in_valid && busy)) |=> !cpu_stall_o)
        else $error("stall without cause");
    drop_rt_only_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        drop_o |-> $past(realtime_mode_i))
        else $error("drop outside realtime mode");
    drop_full_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (realtime_mode_i && in_valid && !in_ready) |=> drop_o)
        else $error("lost record not reported");
    drop_ref_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (in_valid && !in_ready) |=> last_addr == $past(last_addr))
        else $error("reference moved by lost record");
    window_rec_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (window_valid_i && window_en_i && !branch_valid_i) |-> in_valid
        && in_data[35:34] == tac_pkg::KIND_WINDOW && in_data[31:0] == window_addr_i) else $error("bad window record");
    branch_rec_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (branch_valid_i && branch_en_i && !branch_cond_i && !branch_reset_i && !branch_except_i) |-> in_valid
        && in_data[35:34] == tac_pkg::KIND_BRANCH && in_data[31:0] == branch_src_i) else $error("bad branch record");
    hold_stable_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        busy |=> $stable(hold))
        else $error("record word moved while busy");
    req_busy_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (req_tgl != $past(req_tgl)) |-> busy)
        else $error("request without busy");
    ack_busy_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        (ack_s3 != ack_s2) |-> busy)
        else $error("acknowledge while idle");
    sync_pulse_a: assert property (@(posedge trace_port_clock_i) disable iff (!trace_resetn_i)
        trace_sync_o |=> !trace_sync_o)
        else $error("header flag longer than one nibble");
    head_count_a: assert property (@(posedge trace_port_clock_i) disable iff (!trace_resetn_i)
        (state == TAC_DATA && $past(state) == TAC_HEAD) |-> nib_left == (4'h1 << shreg[33:32]))
        else $error("nibble count does not match length code");
    data_nib_a: assert property (@(posedge trace_port_clock_i) disable iff (!trace_resetn_i)
        (state == TAC_DATA) |=> !trace_sync_o && trace_output_port_o == $past(shreg[3:0]))
        else $error("data nibble out of order");
    rec_end_a: assert property (@(posedge trace_port_clock_i) disable iff (!trace_resetn_i)
        (state == TAC_DATA && nib_left == 4'h1) |=> state == TAC_IDLE && ack_tgl != $past(ack_tgl))
        else $error("record end not acknowledged");
    idle_quiet_a: assert property (@(posedge trace_port_clock_i) disable iff (!trace_resetn_i)
        (state == TAC_IDLE) |=> trace_output_port_o == 4'h0 && !trace_sync_o)
        else $error("port active while idle");
endmodule
`default_nettype wire

/* tac_emu_model.sv */
// emulator pod model: decodes trace records and rebuilds full addresses
// assumes a sync-flagged header nibble, then 1/2/4/8 data nibbles lsb first
`timescale 1ns/10ps
`default_nettype none
module tac_emu_model (
    input wire logic trace_port_clock_i,
    input wire logic trace_resetn_i,
    input wire logic [3:0] trace_output_port_i,
    input wire logic trace_sync_i,
    output logic rec_valid_o,
    output logic [3:0] rec_head_o,
    output logic [31:0] rec_addr_o
);
    logic [31:0] acc;
    logic [3:0] left;
    logic [3:0] pos;
    always @(posedge trace_port_clock_i) begin
        rec_valid_o <= 1'b0;
        if (trace_resetn_i !== 1'b1) begin
            acc = 32'h0;
            left = 4'h0;
        end else if (trace_sync_i === 1'b1) begin
            rec_head_o <= trace_output_port_i;
            left = 4'h1 << trace_output_port_i[1:0];
            pos = 4'h0;
        end else if (left != 4'h0) begin
            // differences land on the last rebuilt address
            acc[pos*4 +: 4] = trace_output_port_i;
            pos = pos + 4'h1;
            left = left - 4'h1;
            if (left == 4'h0) begin
                rec_valid_o <= 1'b1;
                rec_addr_o <= acc;
            end
        end
    end
endmodule
`default_nettype wire

/* trace_address_compressor_bench.sv */
// bench for the trace address compressor with an emulator pod model
// assumes a free-running trace port clock below the 50 MHz bound
`timescale 1ns/10ps
`default_nettype none
module trace_address_compressor_bench;
    logic clk = 0, tclk = 0, rstn = 0, trstn = 0, rt = 0, ben = 1, wen = 1;
    logic bv = 0, bcond = 0, brst = 0, bexc = 0, bcmp = 1, wv = 0, st_rt = 0, st_nrt = 0;
    logic [31:0] bsrc = 0, waddr = 0, refa = 0, prev = 0, r;
    logic [7:0] bdisp = 0;
    logic stall, drop, sync, rv;
    logic [3:0] port, head;
    logic [31:0] raddr;
    logic [35:0] exp_q[$];
    logic [31:0] msk [4] = '{32'hF, 32'hFF, 32'hFFFF, 32'hFFFFFFFF};
    int err_total = 0, n_tests = 0, n_drop = 0, cyc = 0, seed = 32'h4FC5;
    initial forever #2 clk = ~clk;
    initial forever #24 tclk = ~tclk;
    tac_compressor u_dut (.core_clk_i(clk), .resetn_i(rstn), .trace_port_clock_i(tclk),
        .trace_resetn_i(trstn), .realtime_mode_i(rt), .branch_en_i(ben), .window_en_i(wen),
        .branch_valid_i(bv), .branch_src_i(bsrc), .branch_cond_i(bcond), .branch_disp_i(bdisp),
        .branch_reset_i(brst), .branch_except_i(bexc), .except_completion_i(bcmp),
        .window_valid_i(wv), .window_addr_i(waddr), .cpu_stall_o(stall), .drop_o(drop),
        .trace_output_port_o(port), .trace_sync_o(sync));
    tac_emu_model u_emu (.trace_port_clock_i(tclk), .trace_resetn_i(trstn), .trace_output_port_i(port),
        .trace_sync_i(sync), .rec_valid_o(rv), .rec_head_o(head), .rec_addr_o(raddr));
    task automatic complete_run();
        if (err_total == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic bad(input string m);
        err_total++;
        $display("BAD %0t %s", $time, m);
    endtask
    task automatic chk_rec(input logic [35:0] got, input logic [35:0] want);
        n_tests++;
        if (got !== want) bad($sformatf("record %h want %h", got, want));
    endtask
    task automatic chk_flag(input logic got, input logic want, input string m);
        n_tests++;
        if (got !== want) bad(m);
    endtask
    function automatic logic [1:0] len_of(input logic [31:0] a, input logic [31:0] p);
        if (a[31:4] == p[31:4]) return tac_pkg::LEN_4;
        if (a[31:8] == p[31:8]) return tac_pkg::LEN_8;
        if (a[31:16] == p[31:16]) return tac_pkg::LEN_16;
        return tac_pkg::LEN_32;
    endfunction
    // one event: window or branch, with filter and exception qualifiers
    task automatic ev(input logic w, input logic [31:0] a, input logic c, input logic [7:0] d,
        input logic rs, input logic x);
        logic [31:0] a2;
        logic [1:0] k;
        int n;
        n = 0;
        while (stall !== 1'b0 && n < 2000) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 2000) bad("stall stuck");
        bv = !w;
        wv = w;
        bsrc = a;
        waddr = a;
        bcond = c;
        bdisp = d;
        brst = rs;
        bexc = x;
        a2 = (x && bcmp) ? a + tac_pkg::NEXT_INSN_STEP : a;
        k = w ? tac_pkg::KIND_WINDOW : ((x && bcmp) ? tac_pkg::KIND_EXCEPT : tac_pkg::KIND_BRANCH);
        if (w ? wen : (ben && !(c && d == 8'h00) && !rs)) begin
            exp_q.push_back({k, len_of(a2, refa), a2});
            prev = refa;
            refa = a2;
        end
        @(posedge clk);
        #1;
        bv = 0;
        wv = 0;
        @(posedge clk);
        #1;
    endtask
    task automatic drain();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 20000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk_flag(exp_q.size() == 0, 1'b1, "records missing");
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc > 60000) begin
            bad("timeout");
            complete_run();
        end
        if (stall === 1'b1) begin
            if (rt) st_rt = 1;
            else st_nrt = 1;
        end
        if (drop === 1'b1) begin
            n_drop++;
            void'(exp_q.pop_back());
            refa = prev;
        end
    end
    always @(posedge tclk) begin
        if (rv === 1'b1) begin
            if (exp_q.size() == 0) bad("extra record");
            else chk_rec({head, raddr}, exp_q.pop_front());
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        #1 rstn = 1;
        repeat (12) @(posedge clk);
        #1 trstn = 1;
        ev(0, 32'h12345678, 0, 8'h00, 0, 0);
        ev(0, 32'h1234ABCD, 0, 8'h00, 0, 0);
        ev(1, 32'h1234AB10, 0, 8'h00, 0, 0);
        ev(0, 32'h1234AB1F, 1, 8'h04, 0, 0);
        ev(0, 32'h1234AB00, 1, 8'h00, 0, 0);
        ev(0, tac_pkg::RESET_VECTOR, 0, 8'h00, 1, 0);
        ev(0, 32'h1234AB4E, 0, 8'h00, 0, 1);
        ben = 0;
        ev(0, 32'h55550000, 0, 8'h00, 0, 0);
        ben = 1;
        wen = 0;
        ev(1, 32'h66660000, 0, 8'h00, 0, 0);
        wen = 1;
        for (int i = 0; i < 40; i++) begin
            r = $random(seed);
            bcmp = r[13] | r[14];
            ev(r[0], refa ^ ($random(seed) & msk[r[2:1]]), r[3], r[11:4], 1'b0, r[12] & ~r[0]);
        end
        drain();
        chk_flag(st_nrt, 1'b1, "no stall in non-realtime");
        rt = 1;
        for (int i = 0; i < 8; i++) begin
            ev(1'b0, $random(seed), 1'b0, 8'h00, 1'b0, 1'b0);
        end
        drain();
        chk_flag(n_drop > 0, 1'b1, "no drop in realtime");
        chk_flag(st_rt, 1'b0, "stall in realtime");
        complete_run();
    end
endmodule
`default_nettype wire
